// File: src/emp_port.sv
// external memory port: access sequencer, pin drivers and their checks
// Notes on behaviour
// RULE1 - drive sixteen-bit address for external accesses
// RULE2 - address holds last value when idle
// RULE3 - address floats while bus granted
// RULE4 - twenty-four-bit two-way data bus
// RULE5 - data floats during grant or reset
// RULE6 - program select low per program access
// RULE7 - data select low per data access
// RULE8 - space select low Y, high X
// RULE9 - development mode vector fetch drives low
// RULE10 - outside master asserts active-low request
// RULE11 - release port after current instruction
// RULE12 - grant only after port released
// RULE13 - write strobe low per write, floats
// RULE14 - read strobe low per read, floats
// RULE15 - wait input stretches access when set
// RULE16 - hold grant until request drops
// RULE17 - never both selects in one access
`timescale 1ns/10ps
module emp_port
	import emp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// core access request
	input wire logic acc_req,
	input wire logic acc_write,
	input wire emp_space_t acc_space,
	input wire logic [15:0] acc_addr,
	input wire logic [23:0] acc_wdata,
	input wire logic instr_boundary,
	output logic acc_done,
	output logic [23:0] acc_rdata,
	// mode control
	input wire logic [7:0] operating_mode_reg,
	input wire logic dev_mode,
	// address bus
	output logic [15:0] ext_addr_o,
	output logic ext_addr_oe,
	// data bus
	input wire logic [23:0] ext_data_i,
	output logic [23:0] ext_data_o,
	output logic ext_data_oe,
	// strobes
	output logic prog_space_sel_n_o,
	output logic data_space_sel_n_o,
	output logic xy_sel_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic ctl_oe,
	// request/wait and grant
	input wire logic bus_req_n,
	output logic bus_grant_n_o,
	output logic bus_grant_oe
);
	emp_arb_if arb_if(); // sequencer to arbiter link
	emp_state_t state_q; // access sequencer state
	logic wait_mode; // request pin acts as wait input
	logic req_low; // request/wait pin asserted
	logic start; // access begins this cycle
	logic stall; // wait input stretches the access
	logic drive; // port owned by this device
	emp_space_t space_q; // space of current access
	logic write_q; // direction of current access

	assign wait_mode = operating_mode_reg[EMP_MODE_WAIT_BIT];
	assign req_low = !bus_req_n; // RULE10
	assign arb_if.req_mode = !wait_mode;
	assign arb_if.bus_req = req_low;
	// boundary only counts once no access is running
	assign arb_if.idle = instr_boundary && (state_q == EMP_ST_IDLE);
	assign start = acc_req && (state_q == EMP_ST_IDLE) && !arb_if.hold;
	assign stall = wait_mode && req_low; // RULE15
	assign drive = !arb_if.released;

	// release and grant logic
	emp_arbiter u_arb (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.arb(arb_if.arb)
	);

	// access sequencer: one cycle per access, more while wait held
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_q <= EMP_ST_IDLE;
		end else begin
			unique case (state_q)
				EMP_ST_IDLE: begin
					if (start) begin
						state_q <= EMP_ST_ACCESS;
					end
				end
				EMP_ST_ACCESS: begin
					if (!stall) begin // RULE15
						state_q <= EMP_ST_IDLE;
					end
				end
				default: begin
					state_q <= EMP_ST_IDLE;
				end
			endcase
		end
	end

	// latch the access attributes at start
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			space_q <= EMP_SP_PROG;
			write_q <= 1'b0;
		end else if (start) begin
			space_q <= acc_space;
			write_q <= acc_write;
		end
	end

	// address: updated only on a new access, held otherwise
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ext_addr_o <= EMP_ADDR_RST;
		end else if (start) begin
			ext_addr_o <= acc_addr; // RULE1 RULE2
		end
	end

	// write data out
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ext_data_o <= EMP_DATA_RST;
		end else if (start && acc_write) begin
			ext_data_o <= acc_wdata; // RULE4
		end
	end

	// output enables: all float in reset and while released
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ext_addr_oe <= 1'b0;
			ext_data_oe <= 1'b0;
			ctl_oe <= 1'b0;
		end else begin
			ext_addr_oe <= drive && !arb_if.hold; // RULE3 RULE11
			ctl_oe <= drive && !arb_if.hold; // RULE6 RULE7 RULE9 RULE13
			// data driven only during a write access
			ext_data_oe <= !arb_if.hold &&
				((start && acc_write) ||
				(state_q == EMP_ST_ACCESS && write_q && stall)); // RULE5
		end
	end

	// strobes: exactly one select per access
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prog_space_sel_n_o <= 1'b1;
			data_space_sel_n_o <= 1'b1;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			xy_sel_o <= 1'b1;
		end else if (start ||
			(state_q == EMP_ST_ACCESS && stall)) begin
			// new access, or stretch the running one
			if (start) begin
				prog_space_sel_n_o <= !(acc_space == EMP_SP_PROG); // RULE6 RULE17
				data_space_sel_n_o <= (acc_space == EMP_SP_PROG); // RULE7 RULE17
				rd_n_o <= acc_write; // RULE14
				wr_n_o <= !acc_write; // RULE13
				// Y and development-mode vector fetch drive low
				xy_sel_o <= !((acc_space == EMP_SP_Y) ||
					(acc_space == EMP_SP_VEC && dev_mode)); // RULE8 RULE9
			end
		end else begin
			prog_space_sel_n_o <= 1'b1;
			data_space_sel_n_o <= 1'b1;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
		end
	end

	// read data capture and completion pulse at end of access
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			acc_done <= 1'b0;
			acc_rdata <= EMP_DATA_RST;
		end else begin
			acc_done <= (state_q == EMP_ST_ACCESS) && !stall;
			if (state_q == EMP_ST_ACCESS && !stall && !write_q) begin
				acc_rdata <= ext_data_i; // RULE4
			end
		end
	end

	// grant pin, driven only while the request role is active
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bus_grant_n_o <= 1'b1;
			bus_grant_oe <= 1'b0;
		end else begin
			bus_grant_n_o <= !arb_if.grant; // RULE12 RULE16
			bus_grant_oe <= !wait_mode;
		end
	end

	// pins float while grant is shown
	addr_float_a: assert property ( // RULE3
		@(posedge clk_sys) disable iff (!rstn)
		!bus_grant_n_o |-> !ext_addr_oe && !ctl_oe && !ext_data_oe)
		else $error("port driven during grant");
	addr_hold_a: assert property ( // RULE2
		@(posedge clk_sys) disable iff (!rstn)
		!$past(start) |-> $stable(ext_addr_o))
		else $error("address changed while idle");
	sel_excl_a: assert property ( // RULE17
		@(posedge clk_sys) disable iff (!rstn)
		!(!prog_space_sel_n_o && !data_space_sel_n_o))
		else $error("both selects asserted");
	rd_wr_excl_a: assert property ( // RULE13
		@(posedge clk_sys) disable iff (!rstn)
		!(!rd_n_o && !wr_n_o))
		else $error("read and write strobes together");
	sequence wait_held_s;
		state_q == EMP_ST_ACCESS && stall;
	endsequence
	wait_stretch_a: assert property ( // RULE15
		@(posedge clk_sys) disable iff (!rstn)
		wait_held_s |=> state_q == EMP_ST_ACCESS)
		else $error("access ended while wait held");
	read_strobe_a: assert property ( // RULE14
		@(posedge clk_sys) disable iff (!rstn)
		start && !acc_write |=> !rd_n_o && wr_n_o)
		else $error("read strobe missing");
	y_sel_a: assert property ( // RULE8
		@(posedge clk_sys) disable iff (!rstn)
		start && acc_space == EMP_SP_Y |=> !xy_sel_o)
		else $error("space select not low for Y");
	release_a: assert property ( // RULE11
		@(posedge clk_sys) disable iff (!rstn)
		arb_if.req_mode && req_low && arb_if.idle
		|-> ##[1:2] !ext_addr_oe)
		else $error("port not released on request");
endmodule // emp_port

// File: src/emp_pkg.sv
// package of constants and types for the external memory port
package emp_pkg;
	localparam int EMP_ADDR_W = 16;
	localparam int EMP_DATA_W = 24;
	// position of the wait/request select bit in the operating mode word
	localparam int EMP_MODE_WAIT_BIT = 7;
	localparam int EMP_MODE_W = 8;
	// reset values
	localparam logic [15:0] EMP_ADDR_RST = 16'h0000;
	localparam logic [23:0] EMP_DATA_RST = 24'h000000;
	// clock period and access time in ns, access length in cycles
	localparam int EMP_CLK_PERIOD_NS = 10;
	localparam int EMP_ACCESS_NS = 10;
	localparam int EMP_ACCESS_CYC =
		(EMP_ACCESS_NS + EMP_CLK_PERIOD_NS - 1) / EMP_CLK_PERIOD_NS;
	// memory space of a request
	typedef enum logic [1:0] {
		EMP_SP_PROG = 2'b00,
		EMP_SP_X = 2'b01,
		EMP_SP_Y = 2'b10,
		EMP_SP_VEC = 2'b11
	} emp_space_t;
	// port sequencer and arbiter states
	typedef enum logic [2:0] {
		EMP_ST_IDLE = 3'b000,
		EMP_ST_ACCESS = 3'b001,
		EMP_ST_RELEASE = 3'b010,
		EMP_ST_GRANT = 3'b011,
		EMP_ST_RECLAIM = 3'b100
	} emp_state_t;
endpackage : emp_pkg

// File: src/emp_arb_if.sv
// interface between the port sequencer and the bus-release arbiter
`timescale 1ns/10ps
interface emp_arb_if;
	logic idle; // sequencer between accesses (instruction boundary)
	logic req_mode; // request pin acts as bus request
	logic bus_req; // synchronous request, active high
	logic released; // port pins floated
	logic grant; // bus grant asserted
	logic hold; // arbiter forbids new accesses
	modport seq (output idle, output req_mode, output bus_req,
		input released, input grant, input hold);
	modport arb (input idle, input req_mode, input bus_req,
		output released, output grant, output hold);
endinterface : emp_arb_if

// File: src/emp_arbiter.sv
// bus release arbiter: release, grant, wait for request drop, reclaim
`timescale 1ns/10ps
module emp_arbiter
	import emp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// link to the sequencer
	emp_arb_if.arb arb
);
	emp_state_t state_q; // arbiter state

	// release at an instruction boundary, grant one cycle later
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_q <= EMP_ST_IDLE;
		end else begin
			unique case (state_q)
				EMP_ST_IDLE: begin
					if (arb.req_mode && arb.bus_req && arb.idle) begin // RULE11
						state_q <= EMP_ST_RELEASE;
					end
				end
				EMP_ST_RELEASE: begin
					state_q <= EMP_ST_GRANT; // RULE12
				end
				EMP_ST_GRANT: begin
					// hold grant until the request drops
					if (!arb.bus_req || !arb.req_mode) begin // RULE16
						state_q <= EMP_ST_RECLAIM;
					end
				end
				EMP_ST_RECLAIM: begin
					// grant withdrawn one cycle before pins drive again
					state_q <= EMP_ST_IDLE; // RULE16
				end
				EMP_ST_ACCESS: begin
					state_q <= EMP_ST_IDLE;
				end
			endcase
		end
	end

	assign arb.released = (state_q != EMP_ST_IDLE);
	assign arb.grant = (state_q == EMP_ST_GRANT);
	// block a new access as soon as a release is decided
	assign arb.hold = (state_q != EMP_ST_IDLE) ||
		(arb.req_mode && arb.bus_req && arb.idle);

	// grant only follows a released port
	grant_after_rel_a: assert property ( // RULE12
		@(posedge clk_sys) disable iff (!rstn)
		$rose(arb.grant) |-> $past(state_q) == EMP_ST_RELEASE)
		else $error("grant without prior release");
	grant_holds_a: assert property ( // RULE16
		@(posedge clk_sys) disable iff (!rstn)
		arb.grant && arb.bus_req && arb.req_mode |=> arb.grant)
		else $error("grant dropped while request held");
endmodule // emp_arbiter

// File: test/emp_mem_model.sv
// external memory model standing on the far side of the port pins
`timescale 1ns/10ps
module emp_mem_model
	import emp_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// port pins
	input wire logic [15:0] ext_addr,
	input wire logic [23:0] ext_data_o,
	input wire logic ext_data_oe,
	input wire logic prog_sel_n,
	input wire logic xy,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ctl_oe,
	output logic [23:0] ext_data_i
);
	logic [23:0] mem_q [256]; // one word per space and address key
	logic [23:0] last_q = 24'h000000; // last word driven
	logic [7:0] key; // spaces kept apart by the select pins
	logic drv; // memory drives the bus
	assign key = prog_sel_n ? {1'b1, xy, ext_addr[5:0]} :
		{1'b0, ext_addr[6:0]};
	assign drv = ctl_oe && !rd_n && !ext_data_oe;
	// no pull on the data lines, so a floating bus shows the inverse
	assign ext_data_i = drv ? mem_q[key] : ~last_q;
	// store on the edge that ends a write strobe cycle
	always @(posedge clk_sys) begin
		if (ctl_oe && !wr_n && ext_data_oe)
			mem_q[key] <= ext_data_o;
		if (drv)
			last_q <= mem_q[key];
	end
endmodule // emp_mem_model

// File: test/external_memory_port_pins_tb.sv
// self-checking bench for the external memory port
`timescale 1ns/10ps
module external_memory_port_pins_tb;
	import emp_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
	emp_space_t acc_space = EMP_SP_PROG;
	logic [15:0] acc_addr = 16'h0000, a;
	logic [23:0] acc_wdata = 24'h000000, d, acc_rdata, ext_data_i, ext_data_o;
	logic instr_boundary = 1'b1, dev_mode = 1'b0, bus_req_n = 1'b1;
	logic [7:0] operating_mode_reg = 8'h00;
	logic acc_done, ext_addr_oe, ext_data_oe, prog_sel_n, data_sel_n, xy;
	logic rd_n, wr_n, ctl_oe, gnt_n, gnt_oe;
	logic [15:0] ext_addr_o;
	logic [23:0] shadow [256]; // expected memory contents
	logic [24:0] exp_q [$]; // notes: read flag and expected word
	logic [24:0] note;
	int n_errors = 0, num_checks = 0;
	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;
	emp_port emp_port_i (.clk_sys(clk_sys), .rstn(rstn), .acc_req(acc_req),
		.acc_write(acc_write), .acc_space(acc_space), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .instr_boundary(instr_boundary),
		.acc_done(acc_done), .acc_rdata(acc_rdata),
		.operating_mode_reg(operating_mode_reg), .dev_mode(dev_mode),
		.ext_addr_o(ext_addr_o), .ext_addr_oe(ext_addr_oe),
		.ext_data_i(ext_data_i), .ext_data_o(ext_data_o),
		.ext_data_oe(ext_data_oe), .prog_space_sel_n_o(prog_sel_n),
		.data_space_sel_n_o(data_sel_n), .xy_sel_o(xy), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .ctl_oe(ctl_oe), .bus_req_n(bus_req_n),
		.bus_grant_n_o(gnt_n), .bus_grant_oe(gnt_oe));
	emp_mem_model emp_mem_model_i (.clk_sys(clk_sys), .ext_addr(ext_addr_o),
		.ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
		.prog_sel_n(prog_sel_n), .xy(xy), .rd_n(rd_n), .wr_n(wr_n),
		.ctl_oe(ctl_oe), .ext_data_i(ext_data_i));
	// compare one value, count it, report a mismatch
	task automatic check(input string nm, input logic [23:0] s,
		input logic [23:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// reset for five cycles; every pin enable must be off meanwhile
	task automatic do_reset();
		rstn = 1'b0;
		repeat (5) @(negedge clk_sys);
		check("bus_oe_rst", {ext_addr_oe, ext_data_oe}, 0);
		check("sel_oe_rst", ctl_oe, 0);
		check("strb_oe_rst", {ctl_oe, gnt_oe}, 0);
		rstn = 1'b1;
	endtask
	// one access; nw wait cycles are asked through the shared pin
	task automatic acc(input logic w, input emp_space_t sp, input int nw);
		logic x;
		logic [7:0] k;
		int t;
		x = (sp == EMP_SP_Y) ? 1'b0 : (sp == EMP_SP_VEC) ? !dev_mode : 1'b1;
		k = (sp == EMP_SP_PROG) ? {1'b0, a[6:0]} : {1'b1, x, a[5:0]};
		if (w)
			shadow[k] = d;
		exp_q.push_back({!w, shadow[k]});
		acc_req = 1'b1;
		acc_write = w;
		acc_space = sp;
		acc_addr = a;
		acc_wdata = d;
		bus_req_n = (nw == 0);
		@(negedge clk_sys);
		acc_req = 1'b0;
		for (int i = 0; i <= nw; i++) begin
			if (i == nw)
				bus_req_n = 1'b1;
			check("addr", {ext_addr_oe, ext_addr_o}, {1'b1, a});
			check("prog_sel", prog_sel_n, sp != EMP_SP_PROG);
			check("data_sel", data_sel_n, sp == EMP_SP_PROG);
			if (sp != EMP_SP_PROG)
				check("xy", xy, x);
			check("rd_wr", {ctl_oe, rd_n, wr_n}, {1'b1, w, !w});
			check("wdata", {ext_data_oe, w ? ext_data_o : d}, {w, d});
			check("done_early", acc_done, 0);
			@(negedge clk_sys);
		end
		for (t = 0; t < 8 && acc_done !== 1'b1; t++)
			@(negedge clk_sys);
		check("done_late", t, 0);
		check("addr_hold", ext_addr_o, a);
	endtask
	// read data arrives with the done pulse; compare with the oldest note
	always @(posedge clk_sys) begin
		#1;
		if (acc_done === 1'b1) begin
			check("note", exp_q.size() > 0, 1);
			if (exp_q.size() > 0) begin
				note = exp_q.pop_front();
				if (note[24])
					check("rdata", acc_rdata, note[23:0]);
			end
		end
	end
	// watchdog: the whole run needs far less than this
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h6858));
		do_reset();
		// every space, vector fetch in both modes, write then read back
		for (int s = 0; s < 8; s++) begin
			dev_mode = s[0];
			instr_boundary = 1'($urandom);
			a = 16'($urandom);
			d = 24'($urandom);
			acc(1'b1, emp_space_t'(s[2:1]), 0);
			acc(1'b0, emp_space_t'(s[2:1]), 0);
		end
		repeat (3) @(negedge clk_sys);
		check("idle_addr", ext_addr_o, a);
		// wait mode stretches both kinds of access
		operating_mode_reg = 8'h80;
		acc(1'b1, EMP_SP_X, 2);
		check("grant_off", {gnt_oe, gnt_n}, 2'b01);
		acc(1'b0, EMP_SP_X, 3);
		// bus request: no release before the instruction boundary
		operating_mode_reg = 8'h00;
		instr_boundary = 1'b0;
		bus_req_n = 1'b0;
		repeat (3) @(negedge clk_sys);
		check("no_release", {ctl_oe, gnt_n}, 2'b11);
		instr_boundary = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("released", {ext_addr_oe, ext_data_oe, ctl_oe}, 0);
		check("grant_late", gnt_n, 1);
		for (int i = 0; i < 5; i++) begin
			@(negedge clk_sys);
			check("granted", {ext_addr_oe, ext_data_oe, ctl_oe}, 0);
			check("grant_pin", {gnt_oe, gnt_n}, 2'b10);
		end
		bus_req_n = 1'b1;
		for (int t = 0; t < 4 && gnt_n !== 1'b1; t++)
			@(negedge clk_sys);
		check("ungrant", {gnt_n, ctl_oe}, 2'b10);
		@(negedge clk_sys);
		check("reclaim", {ext_addr_oe, ctl_oe}, 2'b11);
		do_reset();
		acc(1'b0, EMP_SP_X, 0);
		check("queue", exp_q.size(), 0);
		report_and_stop();
	end
endmodule // external_memory_port_pins_tb
